// File: verilog/hlcs_pkg.sv
// package for the link control/status register slice
// assumes one controller clock and a plain register port
package hlcs_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CFG_CTL = 8'h44;
  localparam logic [7:0] OFS_RATE_ERR = 8'h48;
  localparam logic [7:0] OFS_FEATURE = 8'h4c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h60;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h64;

  // config/control word field positions
  localparam int CC_PHASE_DIS = 31;
  localparam int CC_WOUT_LSB = 28;
  localparam int CC_WIN_LSB = 24;
  localparam int CC_MAXW_OUT_LSB = 20;
  localparam int CC_MAXW_IN_LSB = 16;
  localparam int CC_TRISTATE = 13;
  localparam int CC_CHK_HI = 9;
  localparam int CC_CHK_LO = 8;
  localparam int CC_SHUTDOWN = 7;
  localparam int CC_CHAIN_END = 6;
  localparam int CC_INIT_DONE = 5;
  localparam int CC_LINK_FAIL = 4;
  localparam int CC_FLOOD_EN = 1;
  localparam int CC_UPPER_OFF = 0;

  // rate/error/version word field positions
  localparam int RE_FREQ_CAP_LSB = 16;
  localparam int RE_OVERFLOW = 13;
  localparam int RE_PROTO = 12;
  localparam int RE_RATE_LSB = 8;
  localparam int RE_VER_LSB = 0;

  // reset and constant values
  localparam logic [2:0] WIDTH_8 = 3'h0;
  localparam logic [2:0] WIDTH_16 = 3'h1;
  localparam logic [2:0] MAX_WIDTH = WIDTH_16;
  localparam logic TRISTATE_RST = 1'h1;
  localparam logic [15:0] FREQ_CAP_RST = 16'h0025;
  localparam logic [3:0] RATE_200 = 4'h0;
  localparam logic [3:0] RATE_400 = 4'h2;
  localparam logic [3:0] RATE_800 = 4'h5;
  localparam logic [31:0] FEATURE_VAL = 32'h00000002;

  // interrupt status/mask bit positions
  localparam int IRQ_CHK_LO = 0;
  localparam int IRQ_CHK_HI = 1;
  localparam int IRQ_OVERFLOW = 2;
  localparam int IRQ_PROTO = 3;
  localparam int IRQ_LINK_FAIL = 4;
  localparam int IRQ_BITS = 5;

  // status levels coming from the link side
  typedef struct packed {
    logic disconnect;
    logic chain_end;
    logic init_done;
    logic link_fail;
    logic chk_err_hi;
    logic chk_err_lo;
    logic overflow;
    logic proto_err;
  } hlcs_link_in_t;

  // controls handed to the phy and link logic
  typedef struct packed {
    logic lower_phy_off;
    logic upper_phy_shutdown;
    logic flood;
    logic [3:0] rate;
    logic [2:0] width_out;
    logic [2:0] width_in;
  } hlcs_link_out_t;

endpackage

// File: verilog/hlcs_regs.sv
// link control/status register slice: config/control, rate/error,
// feature words, plus interrupt status and mask.
// assumes link status pins and the link clock are asynchronous to mclk;
// warm_rst comes from logic on mclk.
//
// Function
// - the receive maximum width field reads as 1, meaning 16 bits.
// - bit 13 resets to 1 and, when set, powers off the phy on disconnect.
// - bit 9 is set on a checksum error on the upper byte lane.
// - bit 8 is set on a checksum error on the lower byte lane.
// - bit 7 set powers off both lanes; clear enables the lower lane.
// - bit 0 powers off the upper lane when set and enables it when clear.
// - bits 6, 5 and 4 show chain end, init done and link failure.
// - with bit 1 set a checksum error floods the link, else never.
// - bits 31:16 read the supported frequency, 0x0025 at reset.
// - bit 13 of the rate word is set on a packet overflow.
// - bit 12 of the rate word is set on an unrecognised command.
// - the rate field codes 0000, 0010, 0101 for 200, 400, 800 MHz.
// - a rate written to bits 11:8 applies only at warm reset or disconnect.
// - the feature word reads constant, only bit 1 set.
// - link widths apply at warm reset or disconnect; cold reset gives max.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps

module hlcs_regs #(
  parameter logic [7:0] VERSION_RST = 8'h01 // arbitrary value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // warm reset request, same clock
  input wire logic warm_rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // link side
  input wire logic link_clk,
  input wire hlcs_pkg::hlcs_link_in_t link_in,
  output hlcs_pkg::hlcs_link_out_t link_out,
  // interrupt
  output logic irq
);

  // sticky set/clear: a set in the clear cycle wins
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  // write strobe for one offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs,
                               input logic s);
    hit = s && (a == ofs);
  endfunction

  // two-flop synchronisers for link clock and status pins
  // the link clock is only sampled, never used as a clock, so its
  // edges are found a few mclk cycles late
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic lclk_prev;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
    end else begin
      sync1 <= {link_clk, link_in};
      sync2 <= sync1;
    end
  end

  hlcs_pkg::hlcs_link_in_t ls;
  logic lclk_s;
  assign lclk_s = sync2[8];
  assign ls = sync2[7:0];

  // link clock edge and disconnect edge detection
  // previous values reset to the idle pin levels, so no false edge
  // shows up right after reset
  logic disc_prev;
  logic lclk_rise;
  logic disc_rise;
  logic fail_prev;
  logic fail_rise;
  always_ff @(posedge mclk) begin
    if (rst) begin
      lclk_prev <= 1'b0;
      disc_prev <= 1'b0;
      fail_prev <= 1'b0;
    end else begin
      lclk_prev <= lclk_s;
      disc_prev <= ls.disconnect;
      fail_prev <= ls.link_fail;
    end
  end
  assign lclk_rise = lclk_s & ~lclk_prev;
  assign disc_rise = ls.disconnect & ~disc_prev;
  assign fail_rise = ls.link_fail & ~fail_prev;

  // error events are taken once per link clock rising edge
  // an error level held over several link clock edges counts again
  // at each edge, which is how a repeated error shows
  logic ev_hi;
  logic ev_lo;
  logic ev_ovf;
  logic ev_proto;
  assign ev_hi = lclk_rise & ls.chk_err_hi;
  assign ev_lo = lclk_rise & ls.chk_err_lo;
  assign ev_ovf = lclk_rise & ls.overflow;
  assign ev_proto = lclk_rise & ls.proto_err;

  // points where pending settings take effect
  // a disconnect counts once, on its synchronised rising edge
  logic apply;
  assign apply = warm_rst | disc_rise;

  // write decode
  // unmapped offsets decode to nothing, so writes there are lost
  logic wr_cc;
  logic wr_re;
  logic wr_st;
  logic wr_mk;
  assign wr_cc = hit(addr, hlcs_pkg::OFS_CFG_CTL, wr);
  assign wr_re = hit(addr, hlcs_pkg::OFS_RATE_ERR, wr);
  assign wr_st = hit(addr, hlcs_pkg::OFS_IRQ_STAT, wr);
  assign wr_mk = hit(addr, hlcs_pkg::OFS_IRQ_MASK, wr);

  // plain writable control bits
  // phase select disable does nothing inside this slice; it is only
  // stored and read back; link_out does not carry it
  logic phase_dis;
  logic tristate_en;
  logic shutdown;
  logic flood_en;
  logic upper_off;
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_dis <= 1'b0;
      tristate_en <= hlcs_pkg::TRISTATE_RST;
      shutdown <= 1'b0;
      flood_en <= 1'b0;
      upper_off <= 1'b0;
    end else if (wr_cc) begin
      phase_dis <= wdata[hlcs_pkg::CC_PHASE_DIS];
      tristate_en <= wdata[hlcs_pkg::CC_TRISTATE];
      shutdown <= wdata[hlcs_pkg::CC_SHUTDOWN];
      flood_en <= wdata[hlcs_pkg::CC_FLOOD_EN];
      upper_off <= wdata[hlcs_pkg::CC_UPPER_OFF];
    end
  end

  // width fields: written value waits for warm reset or disconnect
  // reads return the pending value, so software sees its write
  // before it reaches the link
  logic [2:0] wout_pend;
  logic [2:0] win_pend;
  logic [2:0] wout_act;
  logic [2:0] win_act;
  always_ff @(posedge mclk) begin
    if (rst) begin
      wout_pend <= hlcs_pkg::MAX_WIDTH;
      win_pend <= hlcs_pkg::MAX_WIDTH;
    end else if (wr_cc) begin
      wout_pend <= wdata[hlcs_pkg::CC_WOUT_LSB +: 3];
      win_pend <= wdata[hlcs_pkg::CC_WIN_LSB +: 3];
    end
  end

  // active widths move only at the apply point
  always_ff @(posedge mclk) begin
    if (rst) begin
      wout_act <= hlcs_pkg::MAX_WIDTH;
      win_act <= hlcs_pkg::MAX_WIDTH;
    end else if (apply) begin
      wout_act <= wout_pend;
      win_act <= win_pend;
    end
  end

  // checksum error flags: hardware sets, software may write
  // a written zero clears the flag unless a new error lands in the
  // same cycle, so an error is never lost
  logic chk_hi;
  logic chk_lo;
  always_ff @(posedge mclk) begin
    if (rst) begin
      chk_hi <= 1'b0;
      chk_lo <= 1'b0;
    end else begin
      // hardware set wins over a written zero
      chk_hi <= ev_hi | (wr_cc ? wdata[hlcs_pkg::CC_CHK_HI] : chk_hi);
      chk_lo <= ev_lo | (wr_cc ? wdata[hlcs_pkg::CC_CHK_LO] : chk_lo);
    end
  end

  // rate field: pending and active copies
  // version byte is writable, its reset value arbitrary
  logic [3:0] rate_pend;
  logic [3:0] rate_act;
  logic [7:0] version;
  always_ff @(posedge mclk) begin
    if (rst) begin
      rate_pend <= hlcs_pkg::RATE_200;
      version <= VERSION_RST;
    end else if (wr_re) begin
      rate_pend <= wdata[hlcs_pkg::RE_RATE_LSB +: 4];
      version <= wdata[hlcs_pkg::RE_VER_LSB +: 8];
    end
  end

  // the running rate changes only at warm reset or disconnect
  always_ff @(posedge mclk) begin
    if (rst) begin
      rate_act <= hlcs_pkg::RATE_200;
    end else if (apply) begin
      rate_act <= rate_pend;
    end
  end

  // overflow is read-only: held until a warm reset
  // software cannot clear it; only a warm or cold reset does
  logic overflow;
  always_ff @(posedge mclk) begin
    if (rst) begin
      overflow <= 1'b0;
    end else begin
      overflow <= sticky(overflow, ev_ovf, warm_rst);
    end
  end

  // protocol error: set by hardware, writable by software
  // like the checksum flags, a set in the write cycle wins
  logic proto;
  always_ff @(posedge mclk) begin
    if (rst) begin
      proto <= 1'b0;
    end else begin
      proto <= ev_proto | (wr_re ? wdata[hlcs_pkg::RE_PROTO] : proto);
    end
  end

  // interrupt status, write one to clear, set wins
  // link failure sets on its rising edge only, so a link that stays
  // down does not keep raising the interrupt after a clear
  logic [hlcs_pkg::IRQ_BITS-1:0] istat;
  logic [hlcs_pkg::IRQ_BITS-1:0] imask;
  logic [hlcs_pkg::IRQ_BITS-1:0] iev;
  logic [hlcs_pkg::IRQ_BITS-1:0] iclr;
  always_comb begin
    iev = '0;
    iev[hlcs_pkg::IRQ_CHK_LO] = ev_lo;
    iev[hlcs_pkg::IRQ_CHK_HI] = ev_hi;
    iev[hlcs_pkg::IRQ_OVERFLOW] = ev_ovf;
    iev[hlcs_pkg::IRQ_PROTO] = ev_proto;
    iev[hlcs_pkg::IRQ_LINK_FAIL] = fail_rise;
    iclr = wr_st ? wdata[hlcs_pkg::IRQ_BITS-1:0] : '0;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      istat <= '0;
    end else begin
      for (int i = 0; i < hlcs_pkg::IRQ_BITS; i++) begin
        istat[i] <= sticky(istat[i], iev[i], iclr[i]);
      end
    end
  end

  // mask: a one lets the bit reach the interrupt line
  always_ff @(posedge mclk) begin
    if (rst) begin
      imask <= '0;
    end else if (wr_mk) begin
      imask <= wdata[hlcs_pkg::IRQ_BITS-1:0];
    end
  end

  // interrupt level, one cycle behind the status
  // registered so the pin comes straight from a flip-flop
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(istat & imask);
    end
  end

  // phy controls; disconnect power-off only with tristate enabled
  // bits 7 and 0 act at once; the tristate bit acts only while the
  // synchronised disconnect level stands
  logic disc_off;
  assign disc_off = tristate_en & ls.disconnect;
  hlcs_pkg::hlcs_link_out_t next_out;
  always_comb begin
    next_out.lower_phy_off = shutdown | disc_off;
    // upper lane follows bit 0 unless everything is shut down
    next_out.upper_phy_shutdown = shutdown | upper_off | disc_off;
    // flooding only while enabled and a checksum error stands
    next_out.flood = flood_en & (chk_hi | chk_lo);
    next_out.rate = rate_act;
    next_out.width_out = wout_act;
    next_out.width_in = win_act;
  end

  // all phy and link controls leave through one register stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      link_out <= '0;
    end else begin
      link_out <= next_out;
    end
  end

  // read images; unnamed bits stay zero
  logic [31:0] cc_img;
  logic [31:0] re_img;
  always_comb begin
    cc_img = 32'h00000000;
    cc_img[hlcs_pkg::CC_PHASE_DIS] = phase_dis;
    cc_img[hlcs_pkg::CC_WOUT_LSB +: 3] = wout_pend;
    cc_img[hlcs_pkg::CC_WIN_LSB +: 3] = win_pend;
    cc_img[hlcs_pkg::CC_MAXW_OUT_LSB +: 3] = hlcs_pkg::MAX_WIDTH;
    cc_img[hlcs_pkg::CC_MAXW_IN_LSB +: 3] = hlcs_pkg::MAX_WIDTH;
    cc_img[hlcs_pkg::CC_TRISTATE] = tristate_en;
    cc_img[hlcs_pkg::CC_CHK_HI] = chk_hi;
    cc_img[hlcs_pkg::CC_CHK_LO] = chk_lo;
    cc_img[hlcs_pkg::CC_SHUTDOWN] = shutdown;
    cc_img[hlcs_pkg::CC_CHAIN_END] = ls.chain_end;
    cc_img[hlcs_pkg::CC_INIT_DONE] = ls.init_done;
    cc_img[hlcs_pkg::CC_LINK_FAIL] = ls.link_fail;
    cc_img[hlcs_pkg::CC_FLOOD_EN] = flood_en;
    cc_img[hlcs_pkg::CC_UPPER_OFF] = upper_off;
  end

  always_comb begin
    re_img = 32'h00000000;
    re_img[hlcs_pkg::RE_FREQ_CAP_LSB +: 16] = hlcs_pkg::FREQ_CAP_RST;
    re_img[hlcs_pkg::RE_OVERFLOW] = overflow;
    re_img[hlcs_pkg::RE_PROTO] = proto;
    re_img[hlcs_pkg::RE_RATE_LSB +: 4] = rate_pend;
    re_img[hlcs_pkg::RE_VER_LSB +: 8] = version;
  end

  // read mux; unmapped offsets read zero
  // the strobe gates the mux, so rdata falls back to zero one cycle
  // after the read
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h00000000;
    if (rd) begin
      unique case (addr)
        hlcs_pkg::OFS_CFG_CTL: next_rdata = cc_img;
        hlcs_pkg::OFS_RATE_ERR: next_rdata = re_img;
        hlcs_pkg::OFS_FEATURE: next_rdata = hlcs_pkg::FEATURE_VAL;
        hlcs_pkg::OFS_IRQ_STAT: next_rdata = 32'(istat);
        hlcs_pkg::OFS_IRQ_MASK: next_rdata = 32'(imask);
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // read data stands the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

// File: sim/hlcs_regs_props.sv
// port assertions for the link control/status register slice
// assumes the bind below attaches it to every hlcs_regs instance
`timescale 1ns/1ps
module hlcs_regs_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic warm_rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // link and interrupt
  input wire logic link_clk,
  input wire hlcs_pkg::hlcs_link_in_t link_in,
  input wire hlcs_pkg::hlcs_link_out_t link_out,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // decoded accesses, shared by several properties
  wire logic rcfg = rd && addr == hlcs_pkg::OFS_CFG_CTL;
  wire logic wcfg = wr && addr == hlcs_pkg::OFS_CFG_CTL;
  a_rdata_one_cycle: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  a_max_width_in: assert property (
    rcfg |=> rdata[18:16] == 3'h1 && rdata[22:20] == 3'h1)
    else $error("maximum width field wrong");
  a_reserved_zero: assert property (
    rcfg |=> rdata[15:14] == 2'h0 && rdata[12:10] == 3'h0
      && rdata[3:2] == 2'h0 && rdata[27] == 1'h0)
    else $error("reserved bits not zero");
  a_freq_cap: assert property (
    rd && addr == hlcs_pkg::OFS_RATE_ERR |=> rdata[31:16] == 16'h0025)
    else $error("frequency capability wrong");
  a_feature_const: assert property (
    rd && addr == hlcs_pkg::OFS_FEATURE |=> rdata == 32'h00000002)
    else $error("feature word wrong");
  // link_out is registered from the register, so two edges after a write
  a_both_off: assert property (wcfg && wdata[7] ##1 !wr
    |=> link_out.lower_phy_off && link_out.upper_phy_shutdown)
    else $error("shutdown left a lane on");
  a_lower_on: assert property (
    wcfg && !wdata[7] && !wdata[13] ##1 !wr |=> !link_out.lower_phy_off)
    else $error("lower lane not enabled");
  a_upper_only: assert property (
    wcfg && wdata[0] ##1 !wr |=> link_out.upper_phy_shutdown)
    else $error("upper lane not shut down");
  a_flood_off: assert property (
    wcfg && !wdata[1] ##1 !wr |=> !link_out.flood)
    else $error("flood without enable");
  a_rate_hold: assert property ($changed(link_out.rate)
    |-> $past(warm_rst) || $past(warm_rst, 2)
      || $past(link_in.disconnect, 2))
    else $error("rate applied without warm reset or disconnect");
  a_irq_masked: assert property (wr && addr == hlcs_pkg::OFS_IRQ_MASK
    && wdata == 32'h0 ##1 !wr |=> !irq)
    else $error("interrupt with all masked");
endmodule

bind hlcs_regs hlcs_regs_props u_props (.mclk(mclk), .rst(rst),
  .warm_rst(warm_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .link_clk(link_clk), .link_in(link_in),
  .link_out(link_out), .irq(irq));

// File: sim/hlcs_peer.sv
// peer device model: link clock and link status/error levels
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ps
module hlcs_peer (
  // link pins
  output logic link_clk,
  output hlcs_pkg::hlcs_link_in_t link_in
);
  // link clock stands still between error frames
  initial begin
    link_clk = 1'b0;
    link_in = '0;
  end
  // errors held across one 800 ns link clock rising edge
  task automatic frame(input logic [3:0] err);
    #30 link_in[3:0] = err;
    #400 link_clk = 1'b1;
    #400 link_clk = 1'b0;
    link_in[3:0] = 4'h0;
  endtask
  // disconnect, chain end, init done, link fail levels
  task automatic status(input logic [3:0] s);
    #30 link_in[7:4] = s;
  endtask
endmodule

// File: sim/hlcs_regs_tb.sv
// self-checking bench for the link control/status register slice
// assumes the peer model drives the link pins
`timescale 1ns/1ps
module hlcs_regs_tb;
  logic mclk, rst, warm_rst, wr, rd, irq, link_clk;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  hlcs_pkg::hlcs_link_in_t link_in;
  hlcs_pkg::hlcs_link_out_t link_out;
  int n_errors = 0;
  int n_compared = 0;
  hlcs_regs dut (.mclk(mclk), .rst(rst), .warm_rst(warm_rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .link_clk(link_clk), .link_in(link_in), .link_out(link_out),
    .irq(irq));
  hlcs_peer peer (.link_clk(link_clk), .link_in(link_in));
  // 100 ns controller clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // read data only stand in the cycle after the strobe
  task automatic rchk(input string what, input logic [7:0] a,
    input logic [31:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
    chk(what, d, exp);
  endtask
  task automatic warm();
    @(posedge mclk);
    warm_rst <= 1'b1;
    @(posedge mclk);
    warm_rst <= 1'b0;
    cyc(2);
  endtask
  task automatic cfg_out(input logic [31:0] v, input logic [31:0] exp);
    wr_reg(hlcs_pkg::OFS_CFG_CTL, v);
    cyc(2);
    chk("link_out", 32'(link_out), exp);
  endtask
  task automatic t_reset();
    rchk("cfg", hlcs_pkg::OFS_CFG_CTL, 32'h11112000);
    rchk("rate", hlcs_pkg::OFS_RATE_ERR, 32'h00250001);
    rchk("feature", hlcs_pkg::OFS_FEATURE, 32'h00000002);
    rchk("unmapped", 8'h70, 32'h0);
    chk("link_out", 32'(link_out), 32'h009);
    $display("t_reset done");
  endtask
  task automatic t_reserved();
    wr_reg(hlcs_pkg::OFS_FEATURE, 32'hffffffff);
    rchk("feature", hlcs_pkg::OFS_FEATURE, 32'h00000002);
    wr_reg(hlcs_pkg::OFS_CFG_CTL, 32'h0000cc0c);
    rchk("cfg", hlcs_pkg::OFS_CFG_CTL, 32'h00110000);
    chk("width_held", 32'(link_out), 32'h009);
    warm();
    chk("width_new", 32'(link_out), 32'h000);
    $display("t_reserved done");
  endtask
  task automatic t_rate();
    logic [3:0] codes [3];
    logic [3:0] prev;
    logic [15:0] v;
    codes = '{hlcs_pkg::RATE_800, hlcs_pkg::RATE_400, hlcs_pkg::RATE_200};
    prev = 4'h0;
    foreach (codes[i]) begin
      v = {4'h0, codes[i], 8'h01};
      wr_reg(hlcs_pkg::OFS_RATE_ERR, {16'hffff, v});
      rchk("rate_rd", hlcs_pkg::OFS_RATE_ERR, {16'h0025, v});
      chk("rate_held", 32'(link_out.rate), 32'(prev));
      warm();
      chk("rate_new", 32'(link_out.rate), 32'(codes[i]));
      prev = codes[i];
    end
    $display("t_rate done");
  endtask
  task automatic t_phy();
    wr_reg(hlcs_pkg::OFS_RATE_ERR, 32'h00000201);
    cfg_out(32'h00002000, 32'h0000);
    peer.status(4'h8);
    cyc(8);
    chk("disconnect", 32'(link_out), 32'h1880);
    peer.status(4'h0);
    cfg_out(32'h00000000, 32'h0080);
    cfg_out(32'h00000080, 32'h1880);
    cfg_out(32'h00000001, 32'h0880);
    peer.status(4'h7);
    cyc(4);
    rchk("status", hlcs_pkg::OFS_CFG_CTL, 32'h00110071);
    peer.status(4'h0);
    $display("t_phy done");
  endtask
  task automatic t_err();
    wr_reg(hlcs_pkg::OFS_IRQ_STAT, 32'h1f);
    wr_reg(hlcs_pkg::OFS_IRQ_MASK, 32'h1f);
    cfg_out(32'h00000002, 32'h0080);
    peer.frame(4'h4);
    cyc(4);
    rchk("chk_lo", hlcs_pkg::OFS_CFG_CTL, 32'h00110102);
    chk("flood", 32'(link_out), 32'h0480);
    chk("irq", 32'(irq), 32'h1);
    rchk("istat", hlcs_pkg::OFS_IRQ_STAT, 32'h1);
    wr_reg(hlcs_pkg::OFS_IRQ_STAT, 32'h1);
    cfg_out(32'h00000000, 32'h0080);
    chk("irq_clr", 32'(irq), 32'h0);
    peer.frame(4'h8);
    cyc(4);
    rchk("chk_hi", hlcs_pkg::OFS_CFG_CTL, 32'h00110200);
    chk("no_flood", 32'(link_out), 32'h0080);
    peer.frame(4'h3);
    cyc(4);
    rchk("errors", hlcs_pkg::OFS_RATE_ERR, 32'h00253201);
    wr_reg(hlcs_pkg::OFS_RATE_ERR, 32'h00000201);
    rchk("ovf_held", hlcs_pkg::OFS_RATE_ERR, 32'h00252201);
    warm();
    rchk("ovf_warm", hlcs_pkg::OFS_RATE_ERR, 32'h00250201);
    wr_reg(hlcs_pkg::OFS_IRQ_MASK, 32'h0);
    cyc(2);
    chk("irq_mask", 32'(irq), 32'h0);
    wr_reg(hlcs_pkg::OFS_IRQ_MASK, 32'h1f);
    cyc(2);
    chk("irq_unmask", 32'(irq), 32'h1);
    wr_reg(hlcs_pkg::OFS_IRQ_STAT, 32'h1f);
    rchk("istat_w1c", hlcs_pkg::OFS_IRQ_STAT, 32'h0);
    $display("t_err done");
  endtask
  // cold reset in mid-run: every setting falls back to its reset value
  task automatic t_midrst();
    wr_reg(hlcs_pkg::OFS_CFG_CTL, 32'h00000083);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    cyc(2);
    chk("link_out_rst", 32'(link_out), 32'h009);
    rchk("cfg_rst", hlcs_pkg::OFS_CFG_CTL, 32'h11112000);
    rchk("rate_rst", hlcs_pkg::OFS_RATE_ERR, 32'h00250001);
    rchk("mask_rst", hlcs_pkg::OFS_IRQ_MASK, 32'h0);
    chk("irq_rst", 32'(irq), 32'h0);
    $display("t_midrst done");
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog: the tests need well under a millisecond
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    warm_rst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_reserved();
    t_rate();
    t_phy();
    t_err();
    t_midrst();
    report_and_stop();
  end
endmodule
